// *** strunit_pkg.sv ***
/*
 * Shared constants and types for the byte-string compare and search unit:
 * opcodes, register map, status fields, reset values, condition codes and
 * the engine state encoding.
 * Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
 */
package strunit_pkg;

  localparam int LEN_W = 16;
  localparam int ADDR_W = 32;
  localparam int AXI_AW = 8;

  // Opcodes
  localparam logic [7:0] OP_CMP_EQ_LEN = 8'h29;
  localparam logic [7:0] OP_CMP_FILL = 8'h2D;
  localparam logic [7:0] OP_SUBSTR = 8'h39;
  localparam logic [7:0] OP_LOCATE = 8'h3A;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_FILL = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_R0 = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_R1 = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_R2 = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_R3 = 8'h1C;

  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_START = 8;
  localparam int CTRL_FRESH = 9;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_FPD = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_CC_LSB = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Condition codes of the processor_status_longword
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cc_t;

  localparam cc_t CC_RST = 4'h0;
  localparam cc_t CC_EQUAL = 4'h4;
  localparam logic [7:0] OP_RST = 8'h00;
  localparam logic [7:0] FILL_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_FET1 = 3'h3,
    ST_FET2 = 3'h2,
    ST_EVAL = 3'h6
  } state_t;

endpackage : strunit_pkg

// *** byte_compare.sv ***
/*
 * Byte comparator: condition codes for first byte against second byte.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module byte_compare (
  input wire logic [7:0] first_byte,
  input wire logic [7:0] second_byte,
  output strunit_pkg::cc_t flags
);

  always_comb begin
    flags.n = $signed(first_byte) < $signed(second_byte);
    flags.z = first_byte == second_byte;
    flags.v = 1'b0;
    flags.c = first_byte < second_byte;
  end

endmodule : byte_compare

// *** byte_fetch.sv ***
/*
 * Single-byte reader on the processor memory read path.
 * Assumes the memory answers with mem_ready high and the byte on mem_rdata
 * in the same cycle; any number of wait cycles is allowed.
 */
`timescale 1ns/1ps
module byte_fetch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic go,
  input wire logic [strunit_pkg::ADDR_W-1:0] addr,
  output logic mem_req,
  output logic [strunit_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  output logic done,
  output logic [7:0] data
);

  // Request and address held until ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req <= 1'b0;
      mem_addr <= '0;
      done <= 1'b0;
      data <= 8'h00;
    end else if (ce) begin
      done <= 1'b0;
      if (go) begin
        mem_req <= 1'b1;
        mem_addr <= addr;
      end else if (mem_req && mem_ready) begin
        mem_req <= 1'b0;
        done <= 1'b1;
        data <= mem_rdata;
      end
    end
  end

endmodule : byte_fetch

// *** string_unit.sv ***
/*
 * Byte-string execution unit: compare with equal lengths, compare with
 * fill, locate byte and substring search. Working state lives in the
 * R0..R3 control block, which software reads and writes over AXI4-Lite.
 * Assumes one clock, a synchronous active-low reset, and a memory read
 * path that eventually answers every request.
 */
`timescale 1ns/1ps
module string_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [strunit_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [strunit_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic irq_pending,
  output logic mem_req,
  output logic [strunit_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  output strunit_pkg::cc_t cc_flags,
  output logic first_part_done
);

  strunit_pkg::state_t st_r;
  logic [7:0] opc_r;
  logic busy_r;
  logic err_r;
  logic [strunit_pkg::LEN_W-1:0] len1_r;
  logic [strunit_pkg::ADDR_W-1:0] adr1_r;
  logic [strunit_pkg::LEN_W-1:0] len2_r;
  logic [strunit_pkg::ADDR_W-1:0] adr2_r;
  logic [strunit_pkg::LEN_W-1:0] save_r;
  logic [strunit_pkg::LEN_W-1:0] back;
  logic [7:0] fill_r;
  logic [7:0] byte1_r;
  logic [7:0] byte2_r;
  logic aw_full_r;
  logic w_full_r;
  logic [strunit_pkg::AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic start_go;
  logic [7:0] start_op;
  logic cont;
  logic need1;
  logic need2;
  logic fetch_go;
  logic [strunit_pkg::ADDR_W-1:0] fetch_addr;
  logic fetch_done;
  logic [7:0] fetch_data;
  strunit_pkg::cc_t cmp_cc;

  // Merge write data into a word under byte enables
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // Only the four string opcodes start the engine
  function automatic logic legal_op(input logic [7:0] op);
    return op == strunit_pkg::OP_CMP_EQ_LEN || op == strunit_pkg::OP_CMP_FILL ||
           op == strunit_pkg::OP_LOCATE || op == strunit_pkg::OP_SUBSTR;
  endfunction : legal_op

  byte_fetch u_fetch (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .go(fetch_go),
    .addr(fetch_addr),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ready(mem_ready),
    .mem_rdata(mem_rdata),
    .done(fetch_done),
    .data(fetch_data)
  );

  byte_compare u_cmp (
    .first_byte(byte1_r),
    .second_byte(byte2_r),
    .flags(cmp_cc)
  );

  // Write strobe and start decode; a resume keeps the suspended opcode
  always_comb begin
    wr_go = aw_full_r && w_full_r && !bvalid;
    start_op = (first_part_done && !w_data_r[strunit_pkg::CTRL_FRESH]) ? opc_r : w_data_r[7:0];
    start_go = wr_go && aw_addr_r == strunit_pkg::OFS_CTRL && w_strb_r[1] &&
               w_data_r[strunit_pkg::CTRL_START] && !busy_r && legal_op(start_op);
  end

  // Loop conditions per operation
  always_comb begin
    unique case (opc_r)
      strunit_pkg::OP_CMP_FILL: cont = len1_r != '0 || len2_r != '0;
      // Loop while object remains and source is long enough
      strunit_pkg::OP_SUBSTR: cont = len1_r != '0 && len2_r >= len1_r;
      default: cont = len1_r != '0;
    endcase
    // Exhausted side uses the fill byte, no fetch
    need1 = !(opc_r == strunit_pkg::OP_CMP_FILL && len1_r == '0);
    need2 = opc_r != strunit_pkg::OP_LOCATE && !(opc_r == strunit_pkg::OP_CMP_FILL && len2_r == '0);
    back = save_r - len1_r;
  end

  // Fetch only while the loop continues, so empty strings never read
  always_comb begin
    fetch_go = (st_r == strunit_pkg::ST_CHECK && cont && !irq_pending) ||
               (st_r == strunit_pkg::ST_FET1 && fetch_done && need2);
    fetch_addr = (st_r == strunit_pkg::ST_CHECK && need1) ? adr1_r : adr2_r;
  end

  // Engine sequencing, control block and condition codes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= strunit_pkg::ST_IDLE;
      opc_r <= strunit_pkg::OP_RST;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      first_part_done <= 1'b0;
      cc_flags <= strunit_pkg::CC_RST;
      len1_r <= '0;
      adr1_r <= '0;
      len2_r <= '0;
      adr2_r <= '0;
      save_r <= '0;
      fill_r <= strunit_pkg::FILL_RST;
      byte1_r <= 8'h00;
      byte2_r <= 8'h00;
    end else if (ce) begin
      unique case (st_r)
        strunit_pkg::ST_IDLE: begin
          // Software loads the control block while idle
          if (wr_go && !busy_r) begin
            unique case (aw_addr_r)
              strunit_pkg::OFS_R0: len1_r <= 16'(apply_strb({16'h0000, len1_r}, w_data_r, w_strb_r));
              strunit_pkg::OFS_R1: adr1_r <= apply_strb(adr1_r, w_data_r, w_strb_r);
              strunit_pkg::OFS_R2: len2_r <= 16'(apply_strb({16'h0000, len2_r}, w_data_r, w_strb_r));
              strunit_pkg::OFS_R3: adr2_r <= apply_strb(adr2_r, w_data_r, w_strb_r);
              strunit_pkg::OFS_FILL: fill_r <= 8'(apply_strb({24'h000000, fill_r}, w_data_r, w_strb_r));
              default: ;
            endcase
          end
          if (wr_go && aw_addr_r == strunit_pkg::OFS_CTRL && w_data_r[strunit_pkg::CTRL_START] && !busy_r) begin
            err_r <= !start_go;
          end
          if (start_go) begin
            busy_r <= 1'b1;
            opc_r <= start_op;
            st_r <= strunit_pkg::ST_CHECK;
            // A fresh start initialises; a resume keeps saved codes and length
            if (!first_part_done || w_data_r[strunit_pkg::CTRL_FRESH]) begin
              // Empty compare leaves the equal codes
              cc_flags <= strunit_pkg::CC_EQUAL;
              save_r <= len1_r;
              // Equal-length compare mirrors R0 into R2
              if (start_op == strunit_pkg::OP_CMP_EQ_LEN) begin
                len2_r <= len1_r;
              end
            end
            first_part_done <= 1'b0;
          end
        end
        strunit_pkg::ST_CHECK: begin
          if (!cont) begin
            busy_r <= 1'b0;
            st_r <= strunit_pkg::ST_IDLE;
            // Locate: Z only when nothing found
            if (opc_r == strunit_pkg::OP_LOCATE) begin
              cc_flags <= '{n: 1'b0, z: len1_r == '0, v: 1'b0, c: 1'b0};
            end
            // Search tail skips the rest of the source
            if (opc_r == strunit_pkg::OP_SUBSTR) begin
              cc_flags <= '{n: 1'b0, z: len1_r == '0, v: 1'b0, c: 1'b0};
              if (len2_r < len1_r) begin
                adr2_r <= adr2_r + {16'h0000, len2_r};
                len2_r <= '0;
              end
            end
          end else if (irq_pending) begin
            // Block already current; yield with first-part-done
            busy_r <= 1'b0;
            first_part_done <= 1'b1;
            st_r <= strunit_pkg::ST_IDLE;
          end else if (need1) begin
            st_r <= strunit_pkg::ST_FET1;
          end else begin
            byte1_r <= fill_r;
            st_r <= strunit_pkg::ST_FET2;
          end
        end
        strunit_pkg::ST_FET1: begin
          if (fetch_done) begin
            byte1_r <= fetch_data;
            if (need2) begin
              st_r <= strunit_pkg::ST_FET2;
            end else begin
              // Locate and a drained second string compare against fill
              byte2_r <= fill_r;
              st_r <= strunit_pkg::ST_EVAL;
            end
          end
        end
        strunit_pkg::ST_FET2: begin
          if (fetch_done) begin
            byte2_r <= fetch_data;
            st_r <= strunit_pkg::ST_EVAL;
          end
        end
        strunit_pkg::ST_EVAL: begin
          st_r <= strunit_pkg::ST_CHECK;
          unique case (opc_r)
            strunit_pkg::OP_CMP_EQ_LEN: begin
              cc_flags <= cmp_cc;
              // Advance upward on equal, stop on mismatch
              if (cmp_cc.z) begin
                len1_r <= len1_r - 16'h0001;
                len2_r <= len1_r - 16'h0001;
                adr1_r <= adr1_r + 32'h00000001;
                adr2_r <= adr2_r + 32'h00000001;
              end else begin
                busy_r <= 1'b0;
                st_r <= strunit_pkg::ST_IDLE;
              end
            end
            strunit_pkg::OP_CMP_FILL: begin
              cc_flags <= cmp_cc;
              // Each side advances only while it has bytes
              if (cmp_cc.z) begin
                if (len1_r != '0) begin
                  len1_r <= len1_r - 16'h0001;
                  adr1_r <= adr1_r + 32'h00000001;
                end
                if (len2_r != '0) begin
                  len2_r <= len2_r - 16'h0001;
                  adr2_r <= adr2_r + 32'h00000001;
                end
              end else begin
                busy_r <= 1'b0;
                st_r <= strunit_pkg::ST_IDLE;
              end
            end
            strunit_pkg::OP_LOCATE: begin
              // Stop on the located byte, counting it
              if (cmp_cc.z) begin
                cc_flags <= '{n: 1'b0, z: 1'b0, v: 1'b0, c: 1'b0};
                busy_r <= 1'b0;
                st_r <= strunit_pkg::ST_IDLE;
              end else begin
                len1_r <= len1_r - 16'h0001;
                adr1_r <= adr1_r + 32'h00000001;
              end
            end
            default: begin
              // Rewind object, restart one source byte on
              if (cmp_cc.z) begin
                len1_r <= len1_r - 16'h0001;
                adr1_r <= adr1_r + 32'h00000001;
                len2_r <= len2_r - 16'h0001;
                adr2_r <= adr2_r + 32'h00000001;
              end else begin
                adr1_r <= adr1_r - {16'h0000, back};
                len2_r <= len2_r - 16'h0001 + back;
                adr2_r <= adr2_r + 32'h00000001 - {16'h0000, back};
                len1_r <= save_r;
              end
            end
          endcase
        end
        default: st_r <= strunit_pkg::ST_IDLE;
      endcase
    end
  end

  // AXI4-Lite write channels: one write in flight, address and data any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= strunit_pkg::RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_full_r <= 1'b1;
        aw_addr_r <= {awaddr[strunit_pkg::AXI_AW-1:2], 2'b00};
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_full_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid <= 1'b1;
        // Control block writes during a run are dropped, not queued
        unique case (aw_addr_r)
          strunit_pkg::OFS_CTRL, strunit_pkg::OFS_STATUS: bresp <= strunit_pkg::RESP_OKAY;
          strunit_pkg::OFS_FILL, strunit_pkg::OFS_R0, strunit_pkg::OFS_R1,
          strunit_pkg::OFS_R2, strunit_pkg::OFS_R3: bresp <= strunit_pkg::RESP_OKAY;
          default: bresp <= strunit_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; status shows engine state and codes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= strunit_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= strunit_pkg::RESP_OKAY;
        unique case ({araddr[strunit_pkg::AXI_AW-1:2], 2'b00})
          strunit_pkg::OFS_CTRL: rdata <= {24'h000000, opc_r};
          strunit_pkg::OFS_STATUS: rdata <= {24'h000000, cc_flags, 1'b0, err_r, first_part_done, busy_r};
          strunit_pkg::OFS_FILL: rdata <= {24'h000000, fill_r};
          strunit_pkg::OFS_R0: rdata <= {16'h0000, len1_r};
          strunit_pkg::OFS_R1: rdata <= adr1_r;
          strunit_pkg::OFS_R2: rdata <= {16'h0000, len2_r};
          strunit_pkg::OFS_R3: rdata <= adr2_r;
          default: begin
            rdata <= 32'h00000000;
            rresp <= strunit_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : string_unit

// *** string_unit_asserts.sv ***
/*
 * Checker for string_unit: memory request holding, AXI answer timing,
 * suspension cause and the overflow flag.
 * Assumes it is bound to string_unit and that ce stays high.
 */
`timescale 1ns/1ps
module string_unit_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic irq_pending,
  input wire logic mem_req,
  input wire logic [strunit_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_ready,
  input wire strunit_pkg::cc_t cc_flags,
  input wire logic first_part_done
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  mem_hold_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
    else $error("byte request dropped or moved before ready");
  mem_gap_a: assert property (mem_req && mem_ready && ce |=> !mem_req)
    else $error("byte request not released after ready");
  v_clear_a: assert property (cc_flags.v == 1'h0)
    else $error("overflow flag set");
  fpd_cause_a: assert property ($rose(first_part_done) |-> $past(irq_pending))
    else $error("suspension without pending interrupt");
  // Read data must not change while the master stalls
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before rready");
  rd_answer_a: assert property (arvalid && arready && ce |=> rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready && ce |-> ##2 bvalid)
    else $error("write answer late");
  // Single outstanding write: readies stay low while answering
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
endmodule : string_unit_asserts

// *** byte_memory.sv ***
/*
 * Byte memory behind the read path of string_unit.
 * Assumes the bench fills mem and picks wait_cycles between runs.
 */
`timescale 1ns/1ps
module byte_memory (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_req,
  input wire logic [strunit_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_ready,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:1023];
  logic [7:0] last_r = 8'h00;
  int wait_cycles = 0;
  int cnt_r = 0;
  int reads_r = 0;

  assign mem_ready = mem_req && (cnt_r == wait_cycles);
  assign mem_rdata = mem_ready ? mem[mem_addr[9:0]] : ~last_r;

  // Wait counter and tally of bytes handed over
  always @(posedge aclk) begin
    if (!aresetn || mem_ready || !mem_req) cnt_r <= 0;
    else cnt_r <= cnt_r + 1;
    if (mem_ready) begin
      last_r <= mem_rdata;
      reads_r <= reads_r + 1;
    end
  end
endmodule : byte_memory

// *** string_unit_bench.sv ***
/*
 * Bench for string_unit: AXI4-Lite tasks load R0..R3, start each opcode
 * and compare flags and registers with hand-worked results.
 * Assumes byte_memory holds the strings and answers every byte read.
 */
`timescale 1ns/1ps
module string_unit_bench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, irq_pending = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, mem_req, mem_ready, first_part_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, mem_addr;
  logic [7:0] mem_rdata;
  strunit_pkg::cc_t cc_flags;
  int mismatches = 0, compares = 0, tests = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  string_unit string_unit_i (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .irq_pending, .mem_req, .mem_addr, .mem_ready, .mem_rdata, .cc_flags, .first_part_done);
  byte_memory byte_memory_i (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ready, .mem_rdata);

  task cmp_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_word

  task cmp_resp(input logic [1:0] g, input logic [1:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: response %h expected %h", $time, g, e);
    end
  endtask : cmp_resp

  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'h0;
        ad = 1'h1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'h0;
        dd = 1'h1;
      end
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  // Late rready on purpose, so the slave has to hold its answer
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  task go(input logic [7:0] op, input logic fresh);
    logic [31:0] s;
    logic [1:0] r;
    wr(strunit_pkg::OFS_CTRL, {22'h0, fresh, 1'h1, op}, r);
    do rd(strunit_pkg::OFS_STATUS, s, r); while (s[strunit_pkg::STAT_BUSY] !== 1'h0);
  endtask : go

  task load(input logic [7:0] fl, input logic [3:0][31:0] a);
    logic [1:0] r;
    wr(strunit_pkg::OFS_FILL, {24'h0, fl}, r);
    for (int i = 0; i < 4; i++) wr(strunit_pkg::OFS_R0 + 8'(4 * i), a[i], r);
  endtask : load

  task check(input logic [3:0] cc, input logic [3:0][31:0] e, input int n);
    logic [31:0] d;
    logic [1:0] r;
    cmp_word({28'h0, cc_flags}, {28'h0, cc});
    for (int i = 0; i < n; i++) begin
      rd(strunit_pkg::OFS_R0 + 8'(4 * i), d, r);
      cmp_word(d, e[i]);
    end
    tests++;
    $display("test %0d done", tests);
  endtask : check

  task run(input logic [7:0] op, input logic [7:0] fl, input logic [3:0][31:0] a, input logic [3:0] cc,
    input logic [3:0][31:0] e, input int n);
    load(fl, a);
    go(op, 1'h1);
    check(cc, e, n);
  endtask : run

  task put(input int a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) byte_memory_i.mem[a + i] = w[31 - 8 * i -: 8];
  endtask : put

  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int k;
    for (int i = 0; i < 1024; i++) byte_memory_i.mem[i] = 8'h00;
    put(32'h100, 32'h41424344);
    put(32'h200, 32'h41425844);
    put(32'h300, 32'h41424344);
    put(32'h110, 32'h80000000);
    put(32'h210, 32'h01000000);
    put(32'h400, 32'h43440000);
    put(32'h420, 32'h41430000);
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    byte_memory_i.wait_cycles <= 1;
    // Reset values, with the hole at 0x0C
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), d, r);
      cmp_resp(r, i == 3 ? strunit_pkg::RESP_SLVERR : strunit_pkg::RESP_OKAY);
      cmp_word(d, 32'h0);
    end
    wr(8'h0C, 32'hFFFFFFFF, r);
    cmp_resp(r, strunit_pkg::RESP_SLVERR);
    run(8'h29, 8'h00, {32'h200, 32'h4, 32'h100, 32'h4}, 4'h9, {32'h202, 32'h2, 32'h102, 32'h2}, 4);
    run(8'h29, 8'h00, {32'h300, 32'h4, 32'h100, 32'h4}, 4'h4, {32'h304, 32'h0, 32'h104, 32'h0}, 4);
    run(8'h29, 8'h00, {32'h210, 32'h1, 32'h110, 32'h1}, 4'h8, {32'h210, 32'h1, 32'h110, 32'h1}, 4);
    k = byte_memory_i.reads_r;
    run(8'h29, 8'h00, {32'h200, 32'h0, 32'h100, 32'h0}, 4'h4, {32'h200, 32'h0, 32'h100, 32'h0}, 4);
    run(8'h2D, 8'h00, {32'h200, 32'h0, 32'h100, 32'h0}, 4'h4, {32'h200, 32'h0, 32'h100, 32'h0}, 4);
    run(8'h3A, 8'h41, {32'h0, 32'h0, 32'h100, 32'h0}, 4'h4, {32'h0, 32'h0, 32'h100, 32'h0}, 2);
    cmp_word(32'(byte_memory_i.reads_r), 32'(k));
    run(8'h2D, 8'h43, {32'h300, 32'h2, 32'h100, 32'h4}, 4'h0, {32'h302, 32'h0, 32'h103, 32'h1}, 4);
    run(8'h2D, 8'h43, {32'h100, 32'h4, 32'h300, 32'h2}, 4'h9, {32'h103, 32'h1, 32'h302, 32'h0}, 4);
    byte_memory_i.wait_cycles <= 0;
    run(8'h3A, 8'h43, {32'h0, 32'h0, 32'h100, 32'h4}, 4'h0, {32'h0, 32'h0, 32'h102, 32'h2}, 2);
    run(8'h3A, 8'h5A, {32'h0, 32'h0, 32'h100, 32'h4}, 4'h4, {32'h0, 32'h0, 32'h104, 32'h0}, 2);
    run(8'h39, 8'h00, {32'h100, 32'h4, 32'h400, 32'h2}, 4'h4, {32'h104, 32'h0, 32'h402, 32'h0}, 4);
    run(8'h39, 8'h00, {32'h100, 32'h4, 32'h420, 32'h2}, 4'h0, {32'h104, 32'h0, 32'h420, 32'h2}, 4);
    // Interrupt mid-compare on slow memory, then resume
    byte_memory_i.wait_cycles <= 3;
    load(8'h00, {32'h300, 32'h4, 32'h100, 32'h4});
    fork
      begin
        repeat (20) @(posedge aclk);
        irq_pending <= 1'h1;
      end
      go(8'h29, 1'h1);
    join
    cmp_word({31'h0, first_part_done}, 32'h1);
    irq_pending <= 1'h0;
    go(8'h29, 1'h0);
    check(4'h4, {32'h304, 32'h0, 32'h104, 32'h0}, 4);
    // Opcode outside the decoded set
    go(8'h55, 1'h1);
    rd(strunit_pkg::OFS_STATUS, d, r);
    cmp_word({31'h0, d[strunit_pkg::STAT_ERR]}, 32'h1);
    $display("test illegal opcode done");
    finish_test;
  end

  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test;
  end
endmodule : string_unit_bench

bind string_unit string_unit_asserts string_unit_asserts_i (.aclk, .aresetn, .ce, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .arvalid, .arready, .rdata, .rvalid, .rready, .irq_pending, .mem_req,
  .mem_addr, .mem_ready, .cc_flags, .first_part_done);
